// >>> hw/scfd_pkg.sv
// package: register map, field layout, codes and carrier types
package scfd_pkg;

	// register byte offsets on the apb bus
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD0 = 8'h04;
	localparam logic [7:0] OFF_CMD10 = 8'h08;
	localparam logic [7:0] OFF_CMD14 = 8'h0c;
	localparam logic [7:0] OFF_CMD15 = 8'h10;
	localparam logic [7:0] OFF_DESC0 = 8'h14;
	localparam logic [7:0] OFF_PARAM0 = 8'h24;
	localparam logic [7:0] OFF_STATUS = 8'h34;
	localparam logic [7:0] OFF_DECODE = 8'h38;
	localparam logic [7:0] OFF_REFTAG = 8'h3c;
	localparam logic [7:0] OFF_APPTAG = 8'h40;
	localparam int unsigned NUM_DESC_WORDS = 4;
	localparam int unsigned NUM_PARAM_WORDS = 4;

	// control register fields
	localparam int unsigned CTRL_START_BIT = 0;
	localparam int unsigned CTRL_OP_BIT = 1;
	localparam int unsigned CTRL_ID_LSB = 16;
	// status register fields
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_DONE_BIT = 1;
	localparam int unsigned STAT_SCT_LSB = 4;
	localparam int unsigned STAT_SC_LSB = 8;

	// command word field positions
	localparam int unsigned CMD0_GATHER_BIT = 15;
	localparam int unsigned CMD10_KIND_LSB = 8;
	localparam int unsigned CMD10_SKIP_BIT = 3;
	localparam int unsigned CMD10_ACTION_LSB = 0;
	localparam int unsigned CMD15_MASK_LSB = 16;
	localparam int unsigned CMD15_APP_LSB = 0;

	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [7:0] RST_SC = 8'h00;

	// reservation kinds: codes inside this span are defined
	localparam logic [7:0] KIND_MIN = 8'h01;
	localparam logic [7:0] KIND_MAX = 8'h06;

	// completion status codes and code types
	localparam logic [7:0] SC_SUCCESS = 8'h00;
	localparam logic [7:0] SC_INVALID_FIELD = 8'h02;
	localparam logic [7:0] SC_CONFLICT = 8'h80;
	localparam logic [7:0] SC_BAD_PROT = 8'h81;
	localparam logic [2:0] SCT_GENERIC = 3'h0;
	localparam logic [2:0] SCT_CMD_SPECIFIC = 3'h1;

	typedef enum logic [2:0] {
		ACT_ACQUIRE = 3'b000,
		ACT_PREEMPT = 3'b001,
		ACT_PREEMPT_ABORT = 3'b010
	} scfd_action_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DECODE = 2'b01,
		ST_COMPLETE = 2'b10
	} scfd_state_type;

	typedef struct packed {
		logic [7:0] reservation_kind;
		logic skip_key_check;
		logic [2:0] acquire_action;
		logic kind_ok;
		logic action_ok;
		logic [63:0] current_holder_key;
		logic [63:0] preempted_key;
	} scfd_acq_type;

	typedef struct packed {
		logic use_gather;
		logic [63:0] first_page_entry;
		logic [63:0] second_page_entry;
		logic [127:0] first_gather_segment;
	} scfd_desc_type;

	typedef struct packed {
		logic valid;
		logic [31:0] expected_initial_ref_tag;
		logic [15:0] expected_app_tag_mask;
		logic [15:0] expected_app_tag;
	} scfd_prot_type;

	typedef struct packed {
		logic valid;
		logic [2:0] acquire_action;
		logic [7:0] reservation_kind;
		logic skip_key_check;
		logic [63:0] current_holder_key;
		logic [63:0] preempted_key;
	} scfd_resv_type;

	typedef struct packed {
		logic valid;
		logic is_acquire;
		logic [15:0] cmd_id;
		logic [2:0] sct;
		logic [7:0] sc;
	} scfd_cpl_type;

endpackage

// >>> hw/scfd_acq_decode.sv
// reservation acquire field decoder and data descriptor split
`timescale 1ns/1ps
`default_nettype none

module scfd_acq_decode (
	// command words
	input wire logic [31:0] i_command_word_zero,
	input wire logic [31:0] i_cmd10,
	// data descriptor and fetched parameter structure
	input wire logic [127:0] i_desc,
	input wire logic [127:0] i_param,
	// decoded results
	output scfd_pkg::scfd_acq_type o_acq,
	output scfd_pkg::scfd_desc_type o_desc
);

	// defined reservation kinds are one span of codes
	function automatic logic kind_defined(input logic [7:0] k);
		kind_defined = (k >= scfd_pkg::KIND_MIN) && (k <= scfd_pkg::KIND_MAX);
	endfunction

	// preempt forms both use the second key
	function automatic logic is_preempt(input logic [2:0] a);
		is_preempt = (a == scfd_pkg::ACT_PREEMPT) ||
			(a == scfd_pkg::ACT_PREEMPT_ABORT);
	endfunction

	wire logic [7:0] kind_field;
	wire logic [2:0] action_field;
	wire logic gather_sel;

	// dword 10 fields; reserved bits are not looked at
	assign kind_field = i_cmd10[scfd_pkg::CMD10_KIND_LSB +: 8];
	assign action_field = i_cmd10[scfd_pkg::CMD10_ACTION_LSB +: 3];
	assign o_acq.reservation_kind = kind_field;
	assign o_acq.acquire_action = action_field;
	assign o_acq.skip_key_check = i_cmd10[scfd_pkg::CMD10_SKIP_BIT];
	assign o_acq.kind_ok = kind_defined(kind_field);
	assign o_acq.action_ok = is_preempt(action_field) ||
		(action_field == scfd_pkg::ACT_ACQUIRE);

	// keys from the parameter structure, bytes little endian
	assign o_acq.current_holder_key = i_param[63:0];
	assign o_acq.preempted_key = is_preempt(action_field) ?
		i_param[127:64] : 64'h0;

	// descriptor form chosen by command word zero bit 15
	assign gather_sel = i_command_word_zero[scfd_pkg::CMD0_GATHER_BIT];
	assign o_desc.use_gather = gather_sel;
	assign o_desc.first_page_entry = gather_sel ? 64'h0 : i_desc[63:0];
	assign o_desc.second_page_entry = gather_sel ? 64'h0 : i_desc[127:64];
	assign o_desc.first_gather_segment = gather_sel ? i_desc : 128'h0;

endmodule

`default_nettype wire

// >>> hw/scfd_top.sv
// command field decoder for read and reservation acquire, apb registers
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - reference tag from all of dword 14
// - tag mask from dword 15 upper half
// - tag value from dword 15 lower half
// - tags ignored unless namespace has protection
// - every read completes with its status
// - conflicting read attributes report code 80h
// - invalid protection settings report code 81h when namespace has protection
// - acquire, preempt and abort forms supported
// - parameters from dword 10 and host structure
// - bit 15 clear selects two page entries
// - bit 15 set selects one gather segment
// - other command fields treated as reserved
// - reservation kind from dword 10 bits 15:8
// - skip flag bypasses current key comparison
// - action from dword 10 bits 2:0
// - kinds 1h to 6h defined, rest reserved
// - current key from structure bytes 7:0
// - preempted key from bytes 15:8 on preempt
module scfd_top (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// namespace format and read datapath checks
	input wire logic i_ns_prot_formatted,
	input wire logic i_rd_attr_conflict,
	input wire logic i_rd_prot_invalid,
	// decoded outputs
	output scfd_pkg::scfd_prot_type o_prot,
	output scfd_pkg::scfd_resv_type o_resv,
	output scfd_pkg::scfd_desc_type o_desc,
	// completion entry toward the completion queue
	output scfd_pkg::scfd_cpl_type o_cpl
);

	// apply byte enables to a stored word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		merge = r;
	endfunction

	// true when an address falls in a block of words
	function automatic logic in_block(input logic [7:0] a,
		input logic [7:0] base, input int unsigned n);
		in_block = (a >= base) && (a < 8'(base + 8'(4 * n))) &&
			(a[1:0] == 2'b00);
	endfunction

	// software written command words
	logic [31:0] ctrl_q;
	logic [31:0] cmd0_q;
	logic [31:0] cmd10_q;
	logic [31:0] cmd14_q;
	logic [31:0] cmd15_q;
	logic [31:0] desc_q [scfd_pkg::NUM_DESC_WORDS];
	logic [31:0] param_q [scfd_pkg::NUM_PARAM_WORDS];
	// block state
	scfd_pkg::scfd_state_type state_q;
	scfd_pkg::scfd_state_type state_d;
	logic done_q;
	logic done_d;
	logic [2:0] sct_q;
	logic [2:0] sct_d;
	logic [7:0] sc_q;
	logic [7:0] sc_d;
	// bus answer flops
	logic pready_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	// output flops
	scfd_pkg::scfd_prot_type prot_q;
	scfd_pkg::scfd_prot_type prot_d;
	scfd_pkg::scfd_resv_type resv_q;
	scfd_pkg::scfd_resv_type resv_d;
	scfd_pkg::scfd_desc_type desc_out_q;
	scfd_pkg::scfd_cpl_type cpl_q;
	scfd_pkg::scfd_cpl_type cpl_d;

	// decoder wires
	wire logic [127:0] desc_flat;
	wire logic [127:0] param_flat;
	scfd_pkg::scfd_acq_type acq;
	scfd_pkg::scfd_desc_type desc_dec;

	// bus phase decode
	wire logic acc_fire;
	wire logic wr_fire;
	wire logic pready_d;
	wire logic addr_ok;
	wire logic [31:0] rd_word;
	wire logic busy;
	wire logic is_acquire;
	wire logic start;
	wire logic done_clr;
	wire logic [31:0] status_word;
	wire logic [31:0] decode_word;

	// a transfer is answered one cycle into its access phase
	assign pready_d = i_psel & i_penable & ~pready_q;
	assign acc_fire = i_psel & i_penable & pready_q;
	assign wr_fire = acc_fire & i_pwrite;
	assign busy = (state_q != scfd_pkg::ST_IDLE);
	assign is_acquire = ctrl_q[scfd_pkg::CTRL_OP_BIT];

	// start is taken only while idle; a start while busy is dropped
	assign start = wr_fire && (i_paddr == scfd_pkg::OFF_CTRL) &&
		i_pstrb[0] && i_pwdata[scfd_pkg::CTRL_START_BIT] && !busy;
	assign done_clr = wr_fire && (i_paddr == scfd_pkg::OFF_STATUS) &&
		i_pstrb[0] && i_pwdata[scfd_pkg::STAT_DONE_BIT];

	// mapped addresses
	assign addr_ok = (i_paddr == scfd_pkg::OFF_CTRL) ||
		(i_paddr == scfd_pkg::OFF_CMD0) ||
		(i_paddr == scfd_pkg::OFF_CMD10) ||
		(i_paddr == scfd_pkg::OFF_CMD14) ||
		(i_paddr == scfd_pkg::OFF_CMD15) ||
		in_block(i_paddr, scfd_pkg::OFF_DESC0, scfd_pkg::NUM_DESC_WORDS) ||
		in_block(i_paddr, scfd_pkg::OFF_PARAM0, scfd_pkg::NUM_PARAM_WORDS) ||
		(i_paddr == scfd_pkg::OFF_STATUS) ||
		(i_paddr == scfd_pkg::OFF_DECODE) ||
		(i_paddr == scfd_pkg::OFF_REFTAG) ||
		(i_paddr == scfd_pkg::OFF_APPTAG);

	// read-only views of block state
	assign status_word = {16'h0, sc_q, 1'b0, sct_q, 2'b00, done_q, busy};
	assign decode_word = {11'h0, desc_out_q.use_gather, resv_q.skip_key_check,
		resv_q.acquire_action, 8'h0, resv_q.reservation_kind};

	// read data selection
	assign rd_word =
		(i_paddr == scfd_pkg::OFF_CTRL) ? {ctrl_q[31:2], is_acquire, 1'b0} :
		(i_paddr == scfd_pkg::OFF_CMD0) ? cmd0_q :
		(i_paddr == scfd_pkg::OFF_CMD10) ? cmd10_q :
		(i_paddr == scfd_pkg::OFF_CMD14) ? cmd14_q :
		(i_paddr == scfd_pkg::OFF_CMD15) ? cmd15_q :
		in_block(i_paddr, scfd_pkg::OFF_DESC0, scfd_pkg::NUM_DESC_WORDS) ?
			desc_q[2'(8'(i_paddr - scfd_pkg::OFF_DESC0) >> 2)] :
		in_block(i_paddr, scfd_pkg::OFF_PARAM0, scfd_pkg::NUM_PARAM_WORDS) ?
			param_q[2'(8'(i_paddr - scfd_pkg::OFF_PARAM0) >> 2)] :
		(i_paddr == scfd_pkg::OFF_STATUS) ? status_word :
		(i_paddr == scfd_pkg::OFF_DECODE) ? decode_word :
		(i_paddr == scfd_pkg::OFF_REFTAG) ? prot_q.expected_initial_ref_tag :
		(i_paddr == scfd_pkg::OFF_APPTAG) ?
			{prot_q.expected_app_tag_mask, prot_q.expected_app_tag} :
		32'h0000_0000;

	// bus answer registers
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			pready_q <= 1'b0;
			prdata_q <= scfd_pkg::RST_WORD;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= pready_d;
			prdata_q <= (pready_d && !i_pwrite && addr_ok) ? rd_word : 32'h0;
			pslverr_q <= pready_d && !addr_ok; // unmapped gets an error
		end
	end

	// control and command word registers, frozen while busy
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			ctrl_q <= scfd_pkg::RST_WORD;
			cmd0_q <= scfd_pkg::RST_WORD;
			cmd10_q <= scfd_pkg::RST_WORD;
			cmd14_q <= scfd_pkg::RST_WORD;
			cmd15_q <= scfd_pkg::RST_WORD;
		end else if (wr_fire && !busy) begin
			if (i_paddr == scfd_pkg::OFF_CTRL) begin
				ctrl_q <= merge(ctrl_q, i_pwdata, i_pstrb);
			end
			if (i_paddr == scfd_pkg::OFF_CMD0) begin
				cmd0_q <= merge(cmd0_q, i_pwdata, i_pstrb);
			end
			if (i_paddr == scfd_pkg::OFF_CMD10) begin
				cmd10_q <= merge(cmd10_q, i_pwdata, i_pstrb);
			end
			if (i_paddr == scfd_pkg::OFF_CMD14) begin
				cmd14_q <= merge(cmd14_q, i_pwdata, i_pstrb);
			end
			if (i_paddr == scfd_pkg::OFF_CMD15) begin
				cmd15_q <= merge(cmd15_q, i_pwdata, i_pstrb);
			end
		end
	end

	// descriptor and parameter structure words
	for (genvar g = 0; g < scfd_pkg::NUM_DESC_WORDS; g++) begin : g_desc
		localparam logic [7:0] OFF = 8'(scfd_pkg::OFF_DESC0 + 4 * g);
		always_ff @(posedge i_clk_sys) begin
			if (i_sys_rst) begin
				desc_q[g] <= scfd_pkg::RST_WORD;
			end else if (wr_fire && !busy && i_paddr == OFF) begin
				desc_q[g] <= merge(desc_q[g], i_pwdata, i_pstrb);
			end
		end
		assign desc_flat[g*32 +: 32] = desc_q[g];
	end
	for (genvar g = 0; g < scfd_pkg::NUM_PARAM_WORDS; g++) begin : g_param
		localparam logic [7:0] OFF = 8'(scfd_pkg::OFF_PARAM0 + 4 * g);
		always_ff @(posedge i_clk_sys) begin
			if (i_sys_rst) begin
				param_q[g] <= scfd_pkg::RST_WORD;
			end else if (wr_fire && !busy && i_paddr == OFF) begin
				param_q[g] <= merge(param_q[g], i_pwdata, i_pstrb);
			end
		end
		assign param_flat[g*32 +: 32] = param_q[g];
	end

	// dword 10, descriptor and key decode; other fields unused
	scfd_acq_decode u_acq_decode (
		.i_command_word_zero(cmd0_q),
		.i_cmd10(cmd10_q),
		.i_desc(desc_flat),
		.i_param(param_flat),
		.o_acq(acq),
		.o_desc(desc_dec)
	);

	// sequencer and result selection
	always_comb begin
		state_d = state_q;
		sct_d = sct_q;
		sc_d = sc_q;
		prot_d = prot_q;
		prot_d.valid = 1'b0;
		resv_d = resv_q;
		resv_d.valid = 1'b0;
		cpl_d = cpl_q;
		cpl_d.valid = 1'b0;
		case (state_q)
			scfd_pkg::ST_IDLE: begin
				if (start) begin
					state_d = scfd_pkg::ST_DECODE;
				end
			end
			scfd_pkg::ST_DECODE: begin
				state_d = scfd_pkg::ST_COMPLETE;
				if (!is_acquire) begin
					// tags pass only for a protected namespace
					prot_d.valid = i_ns_prot_formatted;
					prot_d.expected_initial_ref_tag =
						i_ns_prot_formatted ? cmd14_q : 32'h0;
					prot_d.expected_app_tag_mask = i_ns_prot_formatted ?
						cmd15_q[scfd_pkg::CMD15_MASK_LSB +: 16] : 16'h0;
					prot_d.expected_app_tag = i_ns_prot_formatted ?
						cmd15_q[scfd_pkg::CMD15_APP_LSB +: 16] : 16'h0;
					// conflict outranks a bad protection setting
					if (i_rd_attr_conflict) begin
						sct_d = scfd_pkg::SCT_CMD_SPECIFIC;
						sc_d = scfd_pkg::SC_CONFLICT;
					end else if (i_ns_prot_formatted && i_rd_prot_invalid) begin
						sct_d = scfd_pkg::SCT_CMD_SPECIFIC;
						sc_d = scfd_pkg::SC_BAD_PROT;
					end else begin
						sct_d = scfd_pkg::SCT_GENERIC;
						sc_d = scfd_pkg::SC_SUCCESS;
					end
				end else if (!acq.kind_ok || !acq.action_ok) begin
					// reserved code: fail with no reservation pulse; descriptor view still loads
					sct_d = scfd_pkg::SCT_GENERIC;
					sc_d = scfd_pkg::SC_INVALID_FIELD;
				end else begin
					// acquire, preempt or preempt with abort
					resv_d.valid = 1'b1;
					resv_d.acquire_action = acq.acquire_action;
					resv_d.reservation_kind = acq.reservation_kind;
					resv_d.skip_key_check = acq.skip_key_check;
					resv_d.current_holder_key = acq.current_holder_key;
					resv_d.preempted_key = acq.preempted_key;
					sct_d = scfd_pkg::SCT_GENERIC;
					sc_d = scfd_pkg::SC_SUCCESS;
				end
			end
			scfd_pkg::ST_COMPLETE: begin
				// one completion entry per command, pass or fail
				cpl_d.valid = 1'b1;
				cpl_d.is_acquire = is_acquire;
				cpl_d.cmd_id = ctrl_q[scfd_pkg::CTRL_ID_LSB +: 16];
				cpl_d.sct = sct_q;
				cpl_d.sc = sc_q;
				state_d = scfd_pkg::ST_IDLE;
			end
			default: begin
				state_d = scfd_pkg::ST_IDLE;
			end
		endcase
	end

	// done is sticky; a new completion wins over a clear
	assign done_d = cpl_d.valid | (done_q & ~done_clr);

	// state and result registers
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			state_q <= scfd_pkg::ST_IDLE;
			done_q <= 1'b0;
			sct_q <= scfd_pkg::SCT_GENERIC;
			sc_q <= scfd_pkg::RST_SC;
			prot_q <= '0;
			resv_q <= '0;
			cpl_q <= '0;
		end else begin
			state_q <= state_d;
			done_q <= done_d;
			sct_q <= sct_d;
			sc_q <= sc_d;
			prot_q <= prot_d;
			resv_q <= resv_d;
			cpl_q <= cpl_d;
		end
	end

	// descriptor view is refreshed as each acquire command is decoded
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			desc_out_q <= '0;
		end else if (state_q == scfd_pkg::ST_DECODE && is_acquire) begin
			desc_out_q <= desc_dec;
		end
	end

	// outputs straight from flops
	assign o_pready = pready_q;
	assign o_prdata = prdata_q;
	assign o_pslverr = pslverr_q;
	assign o_prot = prot_q;
	assign o_resv = resv_q;
	assign o_desc = desc_out_q;
	assign o_cpl = cpl_q;

endmodule

`default_nettype wire

// >>> bench/scfd_chk.sv
// checker: concurrent assertions on the decoder's top-level ports
`timescale 1ns/1ps
`default_nettype none

module scfd_chk (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// read datapath checks
	input wire logic i_ns_prot_formatted,
	input wire logic i_rd_attr_conflict,
	input wire logic i_rd_prot_invalid,
	// decoded outputs and completion
	input wire scfd_pkg::scfd_prot_type o_prot,
	input wire scfd_pkg::scfd_resv_type o_resv,
	input wire scfd_pkg::scfd_desc_type o_desc,
	input wire scfd_pkg::scfd_cpl_type o_cpl
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	// tag pulses only for protected namespaces, completion follows
	prot_fmt_a: assert property (o_prot.valid |-> $past(i_ns_prot_formatted))
		else $error("tag pulse without protected namespace");
	read_cpl_a: assert property (o_prot.valid |=>
		o_cpl.valid && !o_cpl.is_acquire)
		else $error("read completion missing");
	// read status codes from the checks seen at decode
	conflict_code_a: assert property (o_cpl.valid && !o_cpl.is_acquire &&
		$past(i_rd_attr_conflict, 2) |-> o_cpl.sc == scfd_pkg::SC_CONFLICT &&
		o_cpl.sct == scfd_pkg::SCT_CMD_SPECIFIC)
		else $error("conflict status wrong");
	bad_prot_a: assert property (o_cpl.valid && !o_cpl.is_acquire &&
		!$past(i_rd_attr_conflict, 2) && $past(i_ns_prot_formatted, 2) &&
		$past(i_rd_prot_invalid, 2) |-> o_cpl.sc == scfd_pkg::SC_BAD_PROT &&
		o_cpl.sct == scfd_pkg::SCT_CMD_SPECIFIC)
		else $error("protection status wrong");
	// acquire decode: only defined codes pass, then success completes
	resv_legal_a: assert property (o_resv.valid |->
		o_resv.acquire_action <= 3'h2 &&
		o_resv.reservation_kind >= scfd_pkg::KIND_MIN &&
		o_resv.reservation_kind <= scfd_pkg::KIND_MAX)
		else $error("reserved code passed");
	resv_cpl_a: assert property (o_resv.valid |=> o_cpl.valid &&
		o_cpl.is_acquire && o_cpl.sc == scfd_pkg::SC_SUCCESS)
		else $error("acquire completion wrong");
	bad_acq_a: assert property (o_cpl.valid && o_cpl.is_acquire &&
		!$past(o_resv.valid) |-> o_cpl.sc == scfd_pkg::SC_INVALID_FIELD &&
		o_cpl.sct == scfd_pkg::SCT_GENERIC)
		else $error("invalid acquire status wrong");
	pkey_zero_a: assert property (o_resv.valid &&
		o_resv.acquire_action == scfd_pkg::ACT_ACQUIRE |->
		o_resv.preempted_key == 64'h0)
		else $error("preempted key on plain acquire");
	// descriptor halves follow the gather select
	gather_pages_a: assert property (o_desc.use_gather |->
		o_desc.first_page_entry == 64'h0 && o_desc.second_page_entry == 64'h0)
		else $error("page entries set in gather mode");
	page_seg_a: assert property (!o_desc.use_gather |->
		o_desc.first_gather_segment == 128'h0)
		else $error("segment set in page mode");
endmodule

`default_nettype wire

// >>> bench/scfd_host.sv
// host model: apb master that posts command images to the decoder
`timescale 1ns/1ps
`default_nettype none

module scfd_host (
	// clock
	input wire logic i_clk,
	// apb request
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [7:0] o_paddr,
	output logic [31:0] o_pwdata,
	output logic [3:0] o_pstrb,
	// apb answer
	input wire logic [31:0] i_prdata,
	input wire logic i_pready,
	input wire logic i_pslverr
);
	// idle bus at time zero, all lanes enabled
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 8'h00;
		o_pwdata = 32'h0000_0000;
	end
	assign o_pstrb = 4'hf;

	// one transfer, held until pready; data lines scrambled after release
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge i_clk);
		o_psel <= 1'b1;
		o_penable <= 1'b0;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_clk);
		o_penable <= 1'b1;
		do @(posedge i_clk); while (i_pready !== 1'b1);
		q = i_prdata;
		e = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		o_pwdata <= ~d;
	endtask

	// command words, descriptor words and key structure, then start
	task automatic post(input logic [31:0] c0, c10, c14, c15,
		input logic [127:0] dsc, prm, input logic [31:0] ctl);
		logic [31:0] q;
		logic e;
		xfer(1'b1, scfd_pkg::OFF_CMD0, c0, q, e);
		xfer(1'b1, scfd_pkg::OFF_CMD10, c10, q, e);
		xfer(1'b1, scfd_pkg::OFF_CMD14, c14, q, e);
		xfer(1'b1, scfd_pkg::OFF_CMD15, c15, q, e);
		for (int k = 0; k < 4; k++) begin
			xfer(1'b1, scfd_pkg::OFF_DESC0 + 8'(4 * k), dsc[32 * k +: 32], q, e);
			xfer(1'b1, scfd_pkg::OFF_PARAM0 + 8'(4 * k), prm[32 * k +: 32], q, e);
		end
		xfer(1'b1, scfd_pkg::OFF_CTRL, ctl, q, e);
	endtask
endmodule

`default_nettype wire

// >>> bench/scfd_bench.sv
// testbench: command table run, register and reset checks
`timescale 1ns/1ps
`default_nettype none

module scfd_bench;
	typedef struct packed {
		logic op;
		logic gth;
		logic [31:0] c10;
		logic fmt;
		logic cf;
		logic inv;
		logic [2:0] sct;
		logic [7:0] sc;
	} scfd_row_type;
	localparam logic [31:0] C14 = 32'h1234_5678;
	localparam logic [31:0] C15 = 32'habcd_ef01;
	localparam logic [127:0] DSC = 128'h0fed_cba9_8765_4321_0123_4567_89ab_cdef;
	localparam logic [127:0] PRM = 128'h5a5a_0001_a5a5_0002_3c3c_0003_c3c3_0004;
	// reads, then acquires over every action and kind boundary
	scfd_row_type rows [10] = '{
		'{1'b0, 1'b0, 32'h0, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00},
		'{1'b0, 1'b0, 32'h0, 1'b1, 1'b1, 1'b1, 3'h1, 8'h80},
		'{1'b0, 1'b0, 32'h0, 1'b1, 1'b0, 1'b1, 3'h1, 8'h81},
		'{1'b0, 1'b0, 32'h0, 1'b0, 1'b0, 1'b1, 3'h0, 8'h00},
		'{1'b1, 1'b0, 32'h0000_0100, 1'b0, 1'b0, 1'b0, 3'h0, 8'h00},
		'{1'b1, 1'b1, 32'hffff_06f9, 1'b0, 1'b0, 1'b0, 3'h0, 8'h00},
		'{1'b1, 1'b1, 32'h0000_0302, 1'b0, 1'b0, 1'b0, 3'h0, 8'h00},
		'{1'b1, 1'b0, 32'h0000_0103, 1'b0, 1'b0, 1'b0, 3'h0, 8'h02},
		'{1'b1, 1'b0, 32'h0000_0000, 1'b0, 1'b0, 1'b0, 3'h0, 8'h02},
		'{1'b1, 1'b1, 32'h0000_0700, 1'b0, 1'b0, 1'b0, 3'h0, 8'h02}};
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic fmt = 1'b0;
	logic cf = 1'b0;
	logic inv = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] pstrb;
	scfd_pkg::scfd_prot_type prot;
	scfd_pkg::scfd_resv_type resv;
	scfd_pkg::scfd_desc_type desc;
	scfd_pkg::scfd_cpl_type cpl, cpl_q;
	int miscompares = 0;
	int n_checks = 0;
	int n_prot = 0;
	int n_resv = 0;
	int n_cpl = 0;
	int np, nr, nc;
	logic e, ok;
	scfd_row_type r;

	always #4 clk_sys = ~clk_sys;

	scfd_top dut_u (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_ns_prot_formatted(fmt),
		.i_rd_attr_conflict(cf), .i_rd_prot_invalid(inv), .o_prot(prot),
		.o_resv(resv), .o_desc(desc), .o_cpl(cpl));
	scfd_host host_u (.i_clk(clk_sys), .o_psel(psel), .o_penable(penable),
		.o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
		.o_pstrb(pstrb), .i_prdata(prdata), .i_pready(pready),
		.i_pslverr(pslverr));

	// count output pulses and keep the last completion entry
	always @(posedge clk_sys) begin
		if (prot.valid === 1'b1) n_prot++;
		if (resv.valid === 1'b1) n_resv++;
		if (cpl.valid === 1'b1) begin
			n_cpl++;
			cpl_q = cpl;
		end
	end

	task automatic chk(input logic good, input string msg);
		n_checks++;
		if (good !== 1'b1) begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// hang guard well beyond the whole sequence
	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		wrap_up();
	end

	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			r = rows[i];
			@(posedge clk_sys);
			fmt <= r.fmt;
			cf <= r.cf;
			inv <= r.inv;
			np = n_prot;
			nr = n_resv;
			nc = n_cpl;
			host_u.post({16'h0, r.gth, 15'h0}, r.c10, C14, C15, DSC, PRM,
				{16'(i + 1), 14'h0, r.op, 1'b1});
			for (int k = 0; k < 50 && n_cpl == nc; k++) @(posedge clk_sys);
			chk(n_cpl == nc + 1 && cpl_q.cmd_id === 16'(i + 1), "no cpl");
			chk(cpl_q.sct === r.sct && cpl_q.sc === r.sc, "status");
			if (r.op) begin
				ok = (r.sc === 8'h00);
				chk(cpl_q.is_acquire === 1'b1 && n_resv == nr + int'(ok), "resv");
				chk(desc.use_gather === r.gth && desc.first_gather_segment ===
					(r.gth ? DSC : 128'h0), "segment");
				chk(desc.first_page_entry === (r.gth ? 64'h0 : DSC[63:0]) &&
					desc.second_page_entry === (r.gth ? 64'h0 : DSC[127:64]),
					"pages");
				if (ok) begin
					chk(resv.acquire_action === r.c10[2:0] && resv.reservation_kind
						=== r.c10[15:8] && resv.skip_key_check === r.c10[3],
						"fields");
					chk(resv.current_holder_key === PRM[63:0], "cur key");
					chk(resv.preempted_key === (r.c10[2:0] == 3'h0 ? 64'h0 :
						PRM[127:64]), "pre key");
					host_u.xfer(1'b0, scfd_pkg::OFF_DECODE, 32'h0, q, e);
					chk(q === {11'h0, r.gth, r.c10[3], r.c10[2:0], 8'h0,
						r.c10[15:8]}, "decode reg");
				end
			end else begin
				chk(n_prot == np + int'(r.fmt), "prot pulse");
				chk(prot.expected_initial_ref_tag === (r.fmt ? C14 : 32'h0) &&
					{prot.expected_app_tag_mask, prot.expected_app_tag} ===
					(r.fmt ? C15 : 32'h0), "tags");
				host_u.xfer(1'b0, scfd_pkg::OFF_REFTAG, 32'h0, q, e);
				chk(q === (r.fmt ? C14 : 32'h0), "ref tag reg");
				host_u.xfer(1'b0, scfd_pkg::OFF_APPTAG, 32'h0, q, e);
				chk(q === (r.fmt ? C15 : 32'h0), "app tag reg");
			end
			host_u.xfer(1'b0, scfd_pkg::OFF_STATUS, 32'h0, q, e);
			chk(q === {16'h0, r.sc, 1'b0, r.sct, 4'h2}, "status reg");
			host_u.xfer(1'b1, scfd_pkg::OFF_STATUS, 32'h2, q, e);
		end
		// start bit reads back as zero, op and id of the last row stay
		host_u.xfer(1'b0, scfd_pkg::OFF_CTRL, 32'h0, q, e);
		chk(q === 32'h000a_0002 && e === 1'b0, "ctrl readback");
		// unmapped and misaligned places answer with an error
		host_u.xfer(1'b0, 8'h44, 32'h0, q, e);
		chk(e === 1'b1 && q === 32'h0, "unmapped read");
		host_u.xfer(1'b1, 8'h15, 32'hffff_ffff, q, e);
		chk(e === 1'b1, "misaligned write");
		// second reset in mid-run clears outputs and registers
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk(prot === '0 && resv === '0 && desc === '0 && cpl === '0, "rst out");
		sys_rst <= 1'b0;
		host_u.xfer(1'b0, scfd_pkg::OFF_STATUS, 32'h0, q, e);
		chk(q === 32'h0 && e === 1'b0, "rst status");
		host_u.xfer(1'b0, scfd_pkg::OFF_DECODE, 32'h0, q, e);
		chk(q === 32'h0, "rst decode");
		host_u.xfer(1'b0, scfd_pkg::OFF_CMD10, 32'h0, q, e);
		chk(q === 32'h0, "rst cmd word");
		wrap_up();
	end
endmodule

bind scfd_top scfd_chk chk_u (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
	.i_ns_prot_formatted(i_ns_prot_formatted),
	.i_rd_attr_conflict(i_rd_attr_conflict),
	.i_rd_prot_invalid(i_rd_prot_invalid), .o_prot(o_prot), .o_resv(o_resv),
	.o_desc(o_desc), .o_cpl(o_cpl));

`default_nettype wire
